// ### logic/oir_addr_decode.sv
// Address classifier for the OTP identification register bank
`timescale 1ns/1ps
module oir_addr_decode (
    input wire logic [7:0] addr,
    output oir_pkg::oir_class_e cls,
    output logic [4:0] idx
);
    always_comb begin
        cls = oir_pkg::CLS_INVALID;
        idx = 5'h00;
        if (addr == oir_pkg::ADDR_DEV_LOCK) begin
            cls = oir_pkg::CLS_DEV_LOCK;
        end else if (addr >= oir_pkg::ADDR_USER_BANK0 && addr < oir_pkg::ADDR_RSVD_0) begin
            cls = oir_pkg::CLS_USER;
            idx = 5'(addr - oir_pkg::ADDR_USER_BANK0);
        end else if (addr >= oir_pkg::ADDR_USER_BANK1 && addr < oir_pkg::ADDR_USER_LOCK_CRC) begin
            cls = oir_pkg::CLS_USER;
            idx = 5'(addr - oir_pkg::ADDR_USER_BANK1 + 8'(oir_pkg::USER_BANK_LEN));
        end else if (addr == oir_pkg::ADDR_USER_LOCK_CRC) begin
            cls = oir_pkg::CLS_USER_LOCK;
        end else if (addr == oir_pkg::ADDR_RSVD_0 || addr == oir_pkg::ADDR_RSVD_1) begin
            cls = oir_pkg::CLS_RESERVED;
        end else if (addr >= oir_pkg::ADDR_WAFER_NUMBER && addr <= oir_pkg::ADDR_WAFER_Y) begin
            cls = oir_pkg::CLS_TRACE;
            idx = 5'(addr - oir_pkg::ADDR_WAFER_NUMBER);
        end else if (addr == oir_pkg::ADDR_WAFER_LOT_LOW || addr == oir_pkg::ADDR_WAFER_LOT_HIGH) begin
            cls = oir_pkg::CLS_TRACE;
            idx = 5'(addr - oir_pkg::ADDR_WAFER_LOT_LOW + 8'h03);
        end else if (addr[3:0] == 4'hf && addr >= oir_pkg::ADDR_FACT_A_LOCK_CRC) begin
            cls = oir_pkg::CLS_FACT_LOCK;
            idx = 5'(addr[7:4] - 4'ha);
        end
    end
endmodule

// ### logic/oir_crc_scan.sv
// Continuous CRC scanner over the writable register array
`timescale 1ns/1ps
module oir_crc_scan #(
    parameter int NBYTES = 30
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [NBYTES*8-1:0] bytes,
    output logic [3:0] ref_crc,
    output logic crc_err
);
    typedef struct packed {
        logic [4:0] pos;
        logic [3:0] acc;
        logic [3:0] ref_crc;
        logic ref_valid;
        logic err;
    } oir_scan_s;

    oir_scan_s s_q;
    oir_scan_s s_d;
    logic [3:0] next_acc;

    // Byte 0 sits in the lowest lane, i.e. the lowest address
    always_comb begin
        next_acc = oir_pkg::crc4_byte(s_q.acc, bytes[s_q.pos*8 +: 8]); // [R16]
        s_d = s_q;
        if (!run) begin
            s_d.pos = 5'h00;
            s_d.acc = oir_pkg::CRC_SEED; // [R15]
            s_d.ref_valid = 1'b0;
            s_d.err = 1'b0;
        end else if (32'(s_q.pos) == NBYTES - 1) begin // [R14]
            s_d.pos = 5'h00;
            s_d.acc = oir_pkg::CRC_SEED;
            s_d.ref_valid = 1'b1;
            if (!s_q.ref_valid) begin
                s_d.ref_crc = next_acc;
            end else if (next_acc != s_q.ref_crc) begin
                s_d.err = 1'b1; // [R16]
            end
        end else begin
            s_d.pos = s_q.pos + 5'h01;
            s_d.acc = next_acc;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ref_crc = s_q.ref_crc;
    assign crc_err = s_q.err;
endmodule

// ### logic/oir_pkg.sv
// Constants, carriers and CRC helper for the OTP identification register bank
// Summary of operation
// (R1) Read-only wafer number, coordinates, lot bytes
// (R2) Traceability readable only while init flag clear
// (R3) Traceability bytes covered by factory error check
// (R4) User data read/write only while init clear
// (R5) User data covered by user block CRC
// (R6) OTP commit programs user lock/CRC automatically
// (R7) Lock bit 7, identifier 6:4, CRC 3:0
// (R8) Factory identifiers A=001 B=010 C=011 D=101
// (R9) Reserved reads answer validly, reserved bits zero
// (R10) Reserved writes answer validly; host writes zeros
// (R11) Invalid address read answers with zero data
// (R12) Invalid address write dropped, answers zero
// (R13) Read-only write dropped, answers current contents
// (R14) Continuous writable-array CRC once init set
// (R15) CRC polynomial x^4+x^3+1, seed zero
// (R16) MSB first, ascending address, flag mismatch
package oir_pkg;

    localparam logic [7:0] ADDR_DEV_LOCK = 8'h3f;
    localparam logic [7:0] ADDR_USER_BANK0 = 8'h40;
    localparam logic [7:0] ADDR_RSVD_0 = 8'h4f;
    localparam logic [7:0] ADDR_USER_BANK1 = 8'h50;
    localparam logic [7:0] ADDR_USER_LOCK_CRC = 8'h5f;
    localparam logic [7:0] ADDR_FACT_A_LOCK_CRC = 8'haf;
    localparam logic [7:0] ADDR_FACT_B_LOCK_CRC = 8'hbf;
    localparam logic [7:0] ADDR_WAFER_NUMBER = 8'hcb;
    localparam logic [7:0] ADDR_WAFER_X = 8'hcc;
    localparam logic [7:0] ADDR_WAFER_Y = 8'hcd;
    localparam logic [7:0] ADDR_RSVD_1 = 8'hce;
    localparam logic [7:0] ADDR_FACT_C_LOCK_CRC = 8'hcf;
    localparam logic [7:0] ADDR_WAFER_LOT_LOW = 8'hd0;
    localparam logic [7:0] ADDR_WAFER_LOT_HIGH = 8'hd1;
    localparam logic [7:0] ADDR_FACT_D_LOCK_CRC = 8'hdf;
    localparam logic [7:0] ADDR_FACT_E_LOCK_CRC = 8'hef;
    localparam logic [7:0] ADDR_FACT_F_LOCK_CRC = 8'hff;

    localparam int USER_BANK_LEN = 15;
    localparam int USER_LEN = 2 * USER_BANK_LEN;

    // Lock and CRC field layout
    localparam int LOCK_BIT = 7;
    localparam int ID_MSB = 6;
    localparam int ID_LSB = 4;
    localparam int CRC_MSB = 3;

    localparam logic [2:0] BLOCK_ID_A = 3'h1;
    localparam logic [2:0] BLOCK_ID_B = 3'h2;
    localparam logic [2:0] BLOCK_ID_C = 3'h3;
    localparam logic [2:0] BLOCK_ID_D = 3'h5;
    localparam logic [2:0] BLOCK_ID_NONE = 3'h0;

    localparam logic [3:0] CRC_POLY = 4'h9;
    localparam logic [3:0] CRC_SEED = 4'h0;
    localparam logic [7:0] RESP_ZERO = 8'h00;
    localparam logic [7:0] DEV_LOCK_RESET = 8'h00;
    localparam logic [7:0] USER_DATA_RESET = 8'h00;
    localparam logic [7:0] USER_LOCK_RESET = 8'h00;

    typedef enum logic [2:0] {
        CLS_USER,
        CLS_USER_LOCK,
        CLS_DEV_LOCK,
        CLS_FACT_LOCK,
        CLS_TRACE,
        CLS_RESERVED,
        CLS_INVALID
    } oir_class_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } oir_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } oir_resp_s;

    typedef struct packed {
        logic [7:0] wafer_number;
        logic [7:0] wafer_x;
        logic [7:0] wafer_y;
        logic [7:0] wafer_lot_low;
        logic [7:0] wafer_lot_high;
        logic [3:0] crc_a;
        logic [3:0] crc_b;
        logic [3:0] crc_c;
        logic [3:0] crc_d;
    } oir_factory_s;

    // One byte through the CRC, most significant bit first
    function automatic logic [3:0] crc4_byte(input logic [3:0] crc_in, input logic [7:0] b);
        logic [3:0] c;
        logic fb;
        c = crc_in;
        for (int i = 7; i >= 0; i--) begin
            fb = c[3] ^ b[i];
            c = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0); // [R15] [R16]
        end
        return c;
    endfunction

endpackage

// ### logic/oir_regbank.sv
// OTP identification, user data and lock/CRC register bank
`timescale 1ns/1ps
module oir_regbank (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic init_complete_flag,
    input oir_pkg::oir_req_s req,
    output oir_pkg::oir_resp_s resp,
    input oir_pkg::oir_factory_s factory,
    input wire logic user_otp_commit,
    output logic [7:0] device_lock_write,
    output logic user_locked,
    output logic array_crc_err,
    output logic factory_crc_err
);
    typedef struct packed {
        logic [oir_pkg::USER_LEN*8-1:0] user_otp_data;
        logic [7:0] dev_lock;
        logic [7:0] user_lock_crc;
        logic resp_valid;
        logic [7:0] resp_data;
        logic fact_err;
    } oir_bank_s;

    oir_bank_s s_q;
    oir_bank_s s_d;
    oir_pkg::oir_class_e cls;
    logic [4:0] idx;
    logic [7:0] cur;
    logic [3:0] user_crc;
    logic [3:0] trace_crc_c;
    logic [3:0] trace_crc_d;
    logic [(oir_pkg::USER_LEN+1)*8-1:0] scan_bytes;

    function automatic logic [7:0] lock_byte(input logic lock, input logic [2:0] id,
                                             input logic [3:0] crc);
        lock_byte = {lock, id, crc}; // [R7]
    endfunction

    oir_addr_decode u_decode (
        .addr(req.addr),
        .cls(cls),
        .idx(idx)
    );

    // Writable array: user data then user lock byte; device lock stays out
    assign scan_bytes = {s_q.user_lock_crc, s_q.user_otp_data}; // [R14]

    oir_crc_scan #(
        .NBYTES(oir_pkg::USER_LEN + 1)
    ) u_scan (
        .core_clk(core_clk),
        .rst(rst),
        .run(init_complete_flag),
        .bytes(scan_bytes),
        .ref_crc(),
        .crc_err(array_crc_err)
    );

    // User block CRC, ascending address order
    always_comb begin
        user_crc = oir_pkg::CRC_SEED;
        for (int i = 0; i < oir_pkg::USER_LEN; i++) begin
            user_crc = oir_pkg::crc4_byte(user_crc, s_q.user_otp_data[i*8 +: 8]); // [R5]
        end
    end

    // Traceability bytes folded into the factory block checks
    always_comb begin
        trace_crc_c = oir_pkg::crc4_byte(oir_pkg::CRC_SEED, factory.wafer_number);
        trace_crc_c = oir_pkg::crc4_byte(trace_crc_c, factory.wafer_x);
        trace_crc_c = oir_pkg::crc4_byte(trace_crc_c, factory.wafer_y); // [R3]
        trace_crc_d = oir_pkg::crc4_byte(oir_pkg::CRC_SEED, factory.wafer_lot_low);
        trace_crc_d = oir_pkg::crc4_byte(trace_crc_d, factory.wafer_lot_high); // [R3]
    end

    // Current contents of the addressed register
    always_comb begin
        cur = oir_pkg::RESP_ZERO;
        case (cls)
            oir_pkg::CLS_USER: begin
                cur = s_q.user_otp_data[idx*8 +: 8];
            end
            oir_pkg::CLS_USER_LOCK: begin
                cur = s_q.user_lock_crc;
            end
            oir_pkg::CLS_DEV_LOCK: begin
                cur = s_q.dev_lock;
            end
            oir_pkg::CLS_FACT_LOCK: begin
                case (idx)
                    5'h0: cur = lock_byte(1'b1, oir_pkg::BLOCK_ID_A, factory.crc_a); // [R8]
                    5'h1: cur = lock_byte(1'b1, oir_pkg::BLOCK_ID_B, factory.crc_b); // [R8]
                    5'h2: cur = lock_byte(1'b1, oir_pkg::BLOCK_ID_C, factory.crc_c); // [R8]
                    5'h3: cur = lock_byte(1'b1, oir_pkg::BLOCK_ID_D, factory.crc_d); // [R8]
                    default: cur = lock_byte(1'b0, oir_pkg::BLOCK_ID_NONE, 4'h0); // [R8]
                endcase
            end
            oir_pkg::CLS_TRACE: begin
                case (idx)
                    5'h0: cur = factory.wafer_number; // [R1]
                    5'h1: cur = factory.wafer_x; // [R1]
                    5'h2: cur = factory.wafer_y; // [R1]
                    5'h3: cur = factory.wafer_lot_low; // [R1]
                    default: cur = factory.wafer_lot_high; // [R1]
                endcase
            end
            default: begin
                // Reserved bits and locations read as zero
                cur = oir_pkg::RESP_ZERO; // [R9] [R11]
            end
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.resp_valid = 1'b0;
        s_d.fact_err = (trace_crc_c != factory.crc_c) || (trace_crc_d != factory.crc_d);
        if (req.valid) begin
            s_d.resp_valid = 1'b1; // [R9] [R10] [R11] [R12]
            case (cls)
                oir_pkg::CLS_USER: begin
                    // Hidden once init completes; the lock also freezes the data
                    if (init_complete_flag) begin
                        s_d.resp_data = oir_pkg::RESP_ZERO; // [R4]
                    end else if (req.write && !s_q.user_lock_crc[oir_pkg::LOCK_BIT]) begin
                        s_d.user_otp_data[idx*8 +: 8] = req.wdata; // [R4]
                        s_d.resp_data = req.wdata;
                    end else begin
                        s_d.resp_data = cur; // [R4]
                    end
                end
                oir_pkg::CLS_DEV_LOCK: begin
                    if (req.write) begin
                        s_d.dev_lock = req.wdata;
                        s_d.resp_data = req.wdata;
                    end else begin
                        s_d.resp_data = cur;
                    end
                end
                oir_pkg::CLS_TRACE: begin
                    if (init_complete_flag) begin
                        s_d.resp_data = oir_pkg::RESP_ZERO; // [R2]
                    end else begin
                        s_d.resp_data = cur; // [R1] [R13]
                    end
                end
                oir_pkg::CLS_USER_LOCK, oir_pkg::CLS_FACT_LOCK: begin
                    s_d.resp_data = cur; // [R13]
                end
                oir_pkg::CLS_RESERVED: begin
                    // Write accepted with nothing behind it to store
                    s_d.resp_data = oir_pkg::RESP_ZERO; // [R9] [R10]
                end
                default: begin
                    s_d.resp_data = oir_pkg::RESP_ZERO; // [R11] [R12]
                end
            endcase
        end
        // Commit CRC sees the data as it stood before this cycle's write
        if (user_otp_commit) begin
            s_d.user_lock_crc = lock_byte(1'b1, oir_pkg::BLOCK_ID_NONE, user_crc); // [R6] [R7]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q.user_otp_data <= {oir_pkg::USER_LEN{oir_pkg::USER_DATA_RESET}};
            s_q.dev_lock <= oir_pkg::DEV_LOCK_RESET;
            s_q.user_lock_crc <= oir_pkg::USER_LOCK_RESET;
            s_q.resp_valid <= 1'b0;
            s_q.resp_data <= oir_pkg::RESP_ZERO;
            s_q.fact_err <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign resp.valid = s_q.resp_valid;
    assign resp.data = s_q.resp_data;
    assign device_lock_write = s_q.dev_lock;
    assign user_locked = s_q.user_lock_crc[oir_pkg::LOCK_BIT];
    assign factory_crc_err = s_q.fact_err;
endmodule

// ### tb/oir_host_model.sv
// Host controller model driving the register request port
`timescale 1ns/1ps
module oir_host_model (
    input wire logic core_clk,
    output oir_pkg::oir_req_s req,
    input oir_pkg::oir_resp_s resp
);
    initial req = '0;
    // One request held for one edge, then a bounded wait for the answer
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        rdata = 8'h00;
        @(negedge core_clk);
        req = '{1'b1, wr, addr, wdata};
        @(negedge core_clk);
        // Released lines show a changed pattern, not the last value
        req = '{1'b0, ~wr, ~addr, ~wdata};
        while (n < 8 && !ok) begin
            if (resp.valid === 1'b1) begin
                ok = 1'b1;
                rdata = resp.data;
            end else begin
                @(negedge core_clk);
                n++;
            end
        end
    endtask
endmodule

// ### tb/oir_regbank_properties.sv
// Port-level assertions for the OTP identification register bank
`timescale 1ns/1ps
module oir_regbank_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic init_complete_flag,
    input oir_pkg::oir_req_s req,
    input oir_pkg::oir_resp_s resp,
    input oir_pkg::oir_factory_s factory,
    input wire logic user_otp_commit,
    input wire logic [7:0] device_lock_write,
    input wire logic user_locked,
    input wire logic array_crc_err,
    input wire logic factory_crc_err
);
    logic trace_addr;
    assign trace_addr = req.addr inside {8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'hd1};
    default clocking chk_clk @(posedge core_clk);
    endclocking
    default disable iff (rst);
    resp_follows_req_a: assert property (req.valid |=> resp.valid)
        else $error("request not answered next cycle");
    resp_no_spurious_a: assert property (!req.valid |=> !resp.valid)
        else $error("answer without request");
    invalid_zero_a: assert property (
        (req.valid && req.addr inside {[8'h60:8'hae]}) |=> resp.data == 8'h00)
        else $error("unmapped address answered nonzero");
    trace_hidden_a: assert property (
        (req.valid && init_complete_flag && trace_addr) |=> resp.data == 8'h00)
        else $error("trace register visible after init");
    trace_read_a: assert property (
        (req.valid && !init_complete_flag && req.addr == 8'hcb)
        |=> resp.data == $past(factory.wafer_number))
        else $error("wafer number read wrong");
    lot_write_ro_a: assert property (
        (req.valid && req.write && !init_complete_flag && req.addr == 8'hd0)
        |=> resp.data == $past(factory.wafer_lot_low))
        else $error("read-only write answer wrong");
    block_a_layout_a: assert property (
        (req.valid && req.addr == 8'haf)
        |=> resp.data == {1'b1, oir_pkg::BLOCK_ID_A, $past(factory.crc_a)})
        else $error("block A lock byte wrong");
    user_id_zero_a: assert property (
        (req.valid && req.addr == 8'h5f) |=> resp.data[6:4] == 3'h0)
        else $error("user block identifier not zero");
    commit_locks_a: assert property (user_otp_commit |=> user_locked[*3])
        else $error("commit did not set user lock");
    crc_err_clear_a: assert property (!init_complete_flag |=> !array_crc_err)
        else $error("array error set while init clear");
endmodule

bind oir_regbank oir_regbank_properties i_oir_regbank_properties (
    .core_clk(core_clk),
    .rst(rst),
    .init_complete_flag(init_complete_flag),
    .req(req),
    .resp(resp),
    .factory(factory),
    .user_otp_commit(user_otp_commit),
    .device_lock_write(device_lock_write),
    .user_locked(user_locked),
    .array_crc_err(array_crc_err),
    .factory_crc_err(factory_crc_err)
);

// ### tb/testbench.sv
// Self-checking bench for the OTP identification register bank
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic init_complete_flag = 1'b0;
    logic user_otp_commit = 1'b0;
    oir_pkg::oir_req_s req;
    oir_pkg::oir_resp_s resp;
    oir_pkg::oir_factory_s factory;
    logic [7:0] device_lock_write;
    logic user_locked;
    logic array_crc_err;
    logic factory_crc_err;
    logic [7:0] lock_addr [6] = '{8'haf, 8'hbf, 8'hcf, 8'hdf, 8'hef, 8'hff};
    logic [7:0] lock_exp [6];
    logic [3:0] ucrc;
    int err_count = 0;
    int compares = 0;

    always #2.5 core_clk = ~core_clk;

    oir_regbank i_oir_regbank (.core_clk(core_clk), .rst(rst),
        .init_complete_flag(init_complete_flag), .req(req), .resp(resp),
        .factory(factory), .user_otp_commit(user_otp_commit),
        .device_lock_write(device_lock_write), .user_locked(user_locked),
        .array_crc_err(array_crc_err), .factory_crc_err(factory_crc_err));
    oir_host_model i_oir_host_model (.core_clk(core_clk), .req(req), .resp(resp));

    // Own x^4+x^3+1 model, MSB first, kept apart from the design's helper
    function automatic logic [3:0] crc4(input logic [3:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            c = {c[2:0], 1'b0} ^ ((c[3] ^ b[i]) ? 4'h9 : 4'h0);
        end
        return c;
    endfunction

    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                       input logic [7:0] exp, input string name);
        logic [7:0] rd;
        logic ok;
        i_oir_host_model.xfer(wr, a, wd, rd, ok);
        if (!ok) begin
            err_count++;
            $display("ERROR %s expected answer seen none", name);
            finish_test();
        end else begin
            chk(name, exp, rd);
        end
    endtask

    initial begin
        factory = '{8'h21, 8'h07, 8'h0c, 8'h34, 8'h12, 4'h3, 4'hc, 4'h0, 4'h0};
        factory.crc_c = crc4(crc4(crc4(4'h0, 8'h21), 8'h07), 8'h0c);
        factory.crc_d = crc4(crc4(4'h0, 8'h34), 8'h12);
        lock_exp = '{{4'h9, 4'h3}, {4'ha, 4'hc}, {4'hb, factory.crc_c},
                     {4'hd, factory.crc_d}, 8'h00, 8'h00};
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        acc(0, 8'hcb, 8'h00, 8'h21, "wafer_number");
        acc(0, 8'hcc, 8'h00, 8'h07, "wafer_x_coord");
        acc(0, 8'hcd, 8'h00, 8'h0c, "wafer_y_coord");
        acc(0, 8'hd0, 8'h00, 8'h34, "wafer_lot_low");
        acc(0, 8'hd1, 8'h00, 8'h12, "wafer_lot_high");
        acc(1, 8'hd0, 8'h00, 8'h34, "wafer_lot_low write");
        acc(0, 8'hd0, 8'h00, 8'h34, "wafer_lot_low kept");
        $display("Test trace registers done");
        acc(1, 8'h40, 8'h5a, 8'h5a, "user first write");
        acc(1, 8'h5e, 8'ha5, 8'ha5, "user last write");
        acc(0, 8'h40, 8'h00, 8'h5a, "user first read");
        acc(0, 8'h5e, 8'h00, 8'ha5, "user last read");
        acc(1, 8'h4f, 8'h00, 8'h00, "reserved write");
        acc(0, 8'h4f, 8'h00, 8'h00, "reserved read");
        acc(1, 8'h70, 8'hff, 8'h00, "unmapped write");
        acc(0, 8'h70, 8'h00, 8'h00, "unmapped read");
        acc(1, 8'haf, 8'h00, lock_exp[0], "block A write");
        $display("Test user and reserved access done");
        for (int i = 0; i < 6; i++) begin
            acc(0, lock_addr[i], 8'h00, lock_exp[i], "factory lock byte");
        end
        $display("Test factory lock bytes done");
        ucrc = 4'h0;
        for (int i = 0; i < 30; i++) begin
            ucrc = crc4(ucrc, i == 0 ? 8'h5a : (i == 29 ? 8'ha5 : 8'h00));
        end
        user_otp_commit = 1'b1;
        @(negedge core_clk);
        user_otp_commit = 1'b0;
        acc(0, 8'h5f, 8'h00, {4'h8, ucrc}, "user lock byte");
        acc(1, 8'h5f, 8'h00, {4'h8, ucrc}, "user lock write");
        acc(1, 8'h41, 8'hff, 8'h00, "locked user write");
        chk("user_locked", 8'h01, {7'h0, user_locked});
        $display("Test commit done");
        init_complete_flag = 1'b1;
        acc(0, 8'h40, 8'h00, 8'h00, "user hidden");
        acc(0, 8'hcb, 8'h00, 8'h00, "trace hidden");
        repeat (100) @(negedge core_clk);
        chk("array_crc_err", 8'h00, {7'h0, array_crc_err});
        chk("factory_crc_err", 8'h00, {7'h0, factory_crc_err});
        factory.wafer_x = 8'h06;
        repeat (2) @(negedge core_clk);
        chk("factory_crc_err corrupt", 8'h01, {7'h0, factory_crc_err});
        factory.wafer_x = 8'h07;
        acc(1, 8'h3f, 8'h3c, 8'h3c, "device lock write");
        chk("device_lock_write", 8'h3c, device_lock_write);
        repeat (70) @(negedge core_clk);
        // Device lock sits outside the checked array
        chk("array_crc_err lock excluded", 8'h00, {7'h0, array_crc_err});
        chk("factory_crc_err restored", 8'h00, {7'h0, factory_crc_err});
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        chk("device_lock_write reset", 8'h00, device_lock_write);
        chk("user_locked reset", 8'h00, {7'h0, user_locked});
        // Let the reference pass finish before the lock byte moves
        repeat (40) @(negedge core_clk);
        user_otp_commit = 1'b1;
        @(negedge core_clk);
        user_otp_commit = 1'b0;
        repeat (70) @(negedge core_clk);
        chk("array_crc_err corrupt", 8'h01, {7'h0, array_crc_err});
        init_complete_flag = 1'b0;
        repeat (2) @(negedge core_clk);
        chk("array_crc_err cleared", 8'h00, {7'h0, array_crc_err});
        $display("Test error checks done");
        finish_test();
    end
endmodule
